/* File: common/ltmc_defs.svh */
// Behaviour
// - Each transceiver resets to off; off is selectable always and silences the bus.
// - In off mode, bus wake activity is ignored and never reported.
// - Normal transmit/receive mode is accepted only while the chip is in Normal.
// - Dominant applied before enable delay ends is blocked; next dominant bit passes.
// - Receive-only disables the driver, receive output follows bus; Normal or Stop.
// - Wake-capable selectable in Stop, Sleep, Restart, Normal; forced on Fail-Safe entry.
// - Wake is falling edge, dominant beyond filter time, then rising edge.
// - After wake, receive output held low until that transceiver's mode changes or the chip rearms it.
// - Wake in Normal/Stop asserts interrupt; from Sleep/Restart/Fail-Safe requests Restart.
// - After a wake the mode field keeps showing the wake-capable code.
// - Rearm by mode toggle, or on chip entry to Stop, Sleep or Fail-Safe.
// - Wake in Stop/Normal sets wake status and interrupt; no automatic Normal.
// - Wake in Stop enables a disabled watchdog when watchdog-on-bus-wake is set.
// - Wake from Sleep goes Restart then Normal, records source, no interrupt.
// - Transmit dominant beyond timeout disables transmitter until input goes recessive.
// - Transmit timeout sets that transceiver's own fault flag.
// - One setting disables the transmit timeout for all four transceivers.
// - Bus dominant beyond timeout in normal or receive-only sets fault flag only.
// - Bus supply undervoltage forces receive-only behaviour until supply recovers.
// - Low-slope setting latched at chip-select rise, writable only in chip Normal.
// - Flash-speed setting latched at chip-select rise, writable in chip Normal.
// - Wake filter accepts dominant longer than 30 us, rejects pulses of 30 us or shorter.
`ifndef LTMC_DEFS_SVH
`define LTMC_DEFS_SVH
`define LTMC_MODE_OFF 2'h0
`define LTMC_MODE_WAKE 2'h1
`define LTMC_MODE_RXONLY 2'h2
`define LTMC_MODE_NORMAL 2'h3
`define LTMC_CLK_MHZ 200
`define LTMC_WAKE_FILTER_US 30
`define LTMC_WAKE_FILTER_CYC (`LTMC_WAKE_FILTER_US * `LTMC_CLK_MHZ)
`define LTMC_DOM_TIMEOUT_US 20000
`define LTMC_DOM_TIMEOUT_CYC (`LTMC_DOM_TIMEOUT_US * `LTMC_CLK_MHZ)
`define LTMC_ENABLE_DELAY_US 10
`define LTMC_ENABLE_DELAY_CYC (`LTMC_ENABLE_DELAY_US * `LTMC_CLK_MHZ)
`endif

/* File: common/ltmc_pkg.sv */
package ltmc_pkg;
	// Chip operating modes as seen by the transceiver control.
	typedef enum logic [2:0] {
		CHIP_NORMAL,
		CHIP_STOP,
		CHIP_SLEEP,
		CHIP_RESTART,
		CHIP_FAILSAFE
	} ltmc_chip_mode_t;
	// Latched global configuration.
	typedef struct packed {
		logic low_slope;
		logic flash_speed;
	} ltmc_slope_cfg_t;
	// Chip-level wake actions.
	typedef struct packed {
		logic interrupt_n;
		logic go_restart;
		logic watchdog_enable;
	} ltmc_chip_req_t;
endpackage : ltmc_pkg

/* File: hw/ltmc_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ltmc_defs.svh"
module ltmc_top #(
	parameter int WAKE_FILTER_CYC = `LTMC_WAKE_FILTER_CYC,
	parameter int DOM_TIMEOUT_CYC = `LTMC_DOM_TIMEOUT_CYC,
	parameter int ENABLE_DELAY_CYC = `LTMC_ENABLE_DELAY_CYC
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire ltmc_pkg::ltmc_chip_mode_t chip_mode_in,
	input wire logic [1:0] mode_wdata_in [4],
	input wire logic [3:0] mode_write_in,
	input wire logic tx_timeout_control_in,
	input wire logic low_slope_select_in,
	input wire logic flash_speed_select_in,
	input wire logic spi_chip_select_n_in,
	input wire logic watchdog_on_bus_wake_in,
	input wire logic watchdog_enabled_in,
	input wire logic bus_supply_undervoltage_in,
	input wire logic [3:0] bus_transmit_input_in,
	input wire logic [3:0] bus_level_in,
	output logic [3:0] bus_receive_output_out,
	output logic [3:0] driver_dominant_out,
	output logic [1:0] xcvr_mode_field_out [4],
	output logic [3:0] xcvr_fault_flag_out,
	output logic [3:0] wake_status_reg_b_out,
	output ltmc_pkg::ltmc_chip_req_t chip_req_out,
	output ltmc_pkg::ltmc_slope_cfg_t slope_cfg_out
);
	// --------------------------------------------------------------
	// Input synchronisers
	// --------------------------------------------------------------
	logic [3:0] tx_meta;
	logic [3:0] tx_sync;
	logic [3:0] bus_meta;
	logic [3:0] bus_sync;
	logic [3:0] bus_prev;
	logic uv_meta;
	logic uv_sync;
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	// Two flip-flops for every pin-level input.
	always_ff @(posedge clock_in) begin
		tx_meta <= bus_transmit_input_in;
		tx_sync <= tx_meta;
		bus_meta <= bus_level_in;
		bus_sync <= bus_meta;
		bus_prev <= bus_sync;
		uv_meta <= bus_supply_undervoltage_in;
		uv_sync <= uv_meta;
		cs_meta <= spi_chip_select_n_in;
		cs_sync <= cs_meta;
		cs_prev <= cs_sync;
	end

	// --------------------------------------------------------------
	// Chip mode tracking
	// --------------------------------------------------------------
	ltmc_pkg::ltmc_chip_mode_t chip_prev;
	logic rearm_all;
	logic to_failsafe;
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			chip_prev <= ltmc_pkg::CHIP_NORMAL;
		end else begin
			chip_prev <= chip_mode_in;
		end
	end
	// Entry to Stop, Sleep or Fail-Safe rearms; a repeated Stop write leaves the mode unchanged and does not rearm.
	always_comb begin
		to_failsafe = (chip_mode_in == ltmc_pkg::CHIP_FAILSAFE) &&
			(chip_prev != ltmc_pkg::CHIP_FAILSAFE);
		rearm_all = (chip_mode_in != chip_prev) && ((chip_mode_in == ltmc_pkg::CHIP_STOP) ||
			(chip_mode_in == ltmc_pkg::CHIP_SLEEP) || to_failsafe);
	end

	// Checks whether a requested mode is allowed in the current chip mode.
	function automatic logic mode_allowed(input logic [1:0] m, input ltmc_pkg::ltmc_chip_mode_t c);
		logic ok;
		ok = 1'b0;
		case (m)
			`LTMC_MODE_OFF: ok = 1'b1;
			`LTMC_MODE_NORMAL: ok = (c == ltmc_pkg::CHIP_NORMAL);
			`LTMC_MODE_RXONLY: ok = (c == ltmc_pkg::CHIP_NORMAL) ||
				(c == ltmc_pkg::CHIP_STOP);
			default: ok = (c != ltmc_pkg::CHIP_FAILSAFE);
		endcase
		return ok;
	endfunction : mode_allowed

	// --------------------------------------------------------------
	// Per-transceiver state
	// --------------------------------------------------------------
	logic [1:0] mode [4];
	logic [3:0] woken;
	logic [3:0] wake_event;
	logic [3:0] tx_blocked;
	logic [3:0] tx_timed_out;
	logic [3:0] en_done;
	logic [31:0] en_cnt [4];
	logic [31:0] wk_cnt [4];
	logic [31:0] txd_cnt [4];
	logic [31:0] bus_cnt [4];
	logic [3:0] wk_armed;

	for (genvar i = 0; i < 4; i++) begin : g_xcvr
		logic mode_change;
		assign mode_change = mode_write_in[i] && mode_allowed(mode_wdata_in[i], chip_mode_in);

		// Mode field; reset and Fail-Safe entry handled here.
		always_ff @(posedge clock_in) begin
			if (reset_in) begin
				mode[i] <= `LTMC_MODE_OFF;
			end else if (to_failsafe) begin
				mode[i] <= `LTMC_MODE_WAKE;
			end else if (mode_change) begin
				mode[i] <= mode_wdata_in[i];
			end
		end

		// Enable delay restarts whenever the transceiver enters normal.
		always_ff @(posedge clock_in) begin
			if (reset_in || mode[i] != `LTMC_MODE_NORMAL) begin
				en_cnt[i] <= 32'h0000_0000;
				en_done[i] <= 1'b0;
			end else if (en_cnt[i] < ENABLE_DELAY_CYC) begin
				en_cnt[i] <= en_cnt[i] + 32'h0000_0001;
			end else begin
				en_done[i] <= 1'b1;
			end
		end

		// Dominant held at enable completion is blocked until it returns recessive.
		always_ff @(posedge clock_in) begin
			if (reset_in || !en_done[i]) begin
				tx_blocked[i] <= 1'b1;
			end else if (tx_sync[i]) begin
				tx_blocked[i] <= 1'b0;
			end
		end

		// Transmit-dominant timeout, cleared once input returns recessive.
		always_ff @(posedge clock_in) begin
			if (reset_in || tx_sync[i] || tx_timeout_control_in) begin
				txd_cnt[i] <= 32'h0000_0000;
				tx_timed_out[i] <= 1'b0;
			end else if (txd_cnt[i] < DOM_TIMEOUT_CYC) begin
				txd_cnt[i] <= txd_cnt[i] + 32'h0000_0001;
			end else begin
				tx_timed_out[i] <= 1'b1;
			end
		end

		// Bus clamp counter in normal or receive-only modes.
		always_ff @(posedge clock_in) begin
			if (reset_in || bus_sync[i] || !(mode[i] == `LTMC_MODE_NORMAL ||
					mode[i] == `LTMC_MODE_RXONLY)) begin
				bus_cnt[i] <= 32'h0000_0000;
			end else if (bus_cnt[i] <= DOM_TIMEOUT_CYC) begin
				bus_cnt[i] <= bus_cnt[i] + 32'h0000_0001;
			end
		end

		// Fault flag is sticky until reset; it never changes the mode.
		always_ff @(posedge clock_in) begin
			if (reset_in) begin
				xcvr_fault_flag_out[i] <= 1'b0;
			end else if (tx_timed_out[i] || bus_cnt[i] == DOM_TIMEOUT_CYC) begin
				xcvr_fault_flag_out[i] <= 1'b1;
			end
		end

		// Wake filter: falling edge arms, long dominant qualifies, rising edge fires.
		always_ff @(posedge clock_in) begin
			if (reset_in || mode[i] != `LTMC_MODE_WAKE || woken[i]) begin
				wk_cnt[i] <= 32'h0000_0000;
				wk_armed[i] <= 1'b0;
			end else if (bus_prev[i] && !bus_sync[i]) begin
				wk_cnt[i] <= 32'h0000_0000;
				wk_armed[i] <= 1'b1;
			end else if (!bus_sync[i] && wk_cnt[i] < WAKE_FILTER_CYC) begin
				wk_cnt[i] <= wk_cnt[i] + 32'h0000_0001;
			end
		end
		assign wake_event[i] = wk_armed[i] && !bus_prev[i] && bus_sync[i] &&
			(wk_cnt[i] >= WAKE_FILTER_CYC) && !woken[i];

		// Woken state holds until mode change or chip rearm.
		always_ff @(posedge clock_in) begin
			if (reset_in || (mode_change && mode_wdata_in[i] != mode[i]) || rearm_all ||
					to_failsafe) begin
				woken[i] <= 1'b0;
			end else if (wake_event[i]) begin
				woken[i] <= 1'b1;
			end
		end

		// Pin outputs: receive follows bus (held high in off), forced low while woken.
		always_ff @(posedge clock_in) begin
			if (reset_in) begin
				bus_receive_output_out[i] <= 1'b1;
				driver_dominant_out[i] <= 1'b0;
			end else begin
				bus_receive_output_out[i] <= !(woken[i] || wake_event[i]) &&
					(mode[i] == `LTMC_MODE_OFF || bus_sync[i]);
				driver_dominant_out[i] <= (mode[i] == `LTMC_MODE_NORMAL) && !uv_sync &&
					!tx_blocked[i] && !tx_timed_out[i] && !tx_sync[i];
			end
		end
		assign xcvr_mode_field_out[i] = mode[i];
	end

	// --------------------------------------------------------------
	// Chip-level wake actions
	// --------------------------------------------------------------
	logic any_wake;
	logic in_run;
	assign any_wake = |wake_event;
	assign in_run = (chip_mode_in == ltmc_pkg::CHIP_NORMAL) ||
		(chip_mode_in == ltmc_pkg::CHIP_STOP);

	// Interrupt low for Normal/Stop wakes; Restart request otherwise.
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			chip_req_out <= '{interrupt_n: 1'b1, go_restart: 1'b0, watchdog_enable: 1'b0};
		end else begin
			chip_req_out.interrupt_n <= !(any_wake && in_run);
			chip_req_out.go_restart <= any_wake && !in_run;
			chip_req_out.watchdog_enable <= any_wake && chip_mode_in == ltmc_pkg::CHIP_STOP &&
				!watchdog_enabled_in && watchdog_on_bus_wake_in;
		end
	end

	// Wake source recorded per transceiver; reset wins over a set and is the only clear.
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			wake_status_reg_b_out <= 4'h0;
		end else begin
			wake_status_reg_b_out <= wake_status_reg_b_out | wake_event;
		end
	end

	// Slope settings latch on chip-select rise, only in chip Normal.
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			slope_cfg_out <= '0;
		end else if (!cs_prev && cs_sync && chip_mode_in == ltmc_pkg::CHIP_NORMAL) begin
			slope_cfg_out.low_slope <= low_slope_select_in;
			slope_cfg_out.flash_speed <= flash_speed_select_in;
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	a_rx_held_low: assert property (@(posedge clock_in) disable iff (reset_in)
		woken[3] |-> !bus_receive_output_out[3])
		else $error("Receive output not low after wake.");
	a_off_no_wake: assert property (@(posedge clock_in) disable iff (reset_in)
		mode[3] == `LTMC_MODE_OFF |-> !wake_event[3])
		else $error("Wake reported in off mode.");
	a_uv_no_drive: assert property (@(posedge clock_in) disable iff (reset_in)
		uv_sync |=> driver_dominant_out == 4'h0)
		else $error("Driver active in undervoltage.");
	a_wake_int: assert property (@(posedge clock_in) disable iff (reset_in)
		(any_wake && in_run) |=> !chip_req_out.interrupt_n)
		else $error("Interrupt missing on wake.");
	a_sleep_restart: assert property (@(posedge clock_in) disable iff (reset_in)
		(any_wake && chip_mode_in == ltmc_pkg::CHIP_SLEEP) |=>
			chip_req_out.go_restart && chip_req_out.interrupt_n)
		else $error("Sleep wake handled wrongly.");
	a_tx_timeout: assert property (@(posedge clock_in) disable iff (reset_in)
		tx_timed_out[0] |=> !driver_dominant_out[0] && xcvr_fault_flag_out[0])
		else $error("Driver active after timeout.");
	a_mode_keep: assert property (@(posedge clock_in) disable iff (reset_in)
		(woken[3] && !mode_write_in[3] && !to_failsafe) |=> $stable(mode[3]))
		else $error("Mode field changed after wake.");
	a_normal_gate: assert property (@(posedge clock_in) disable iff (reset_in)
		(mode[0] != `LTMC_MODE_NORMAL && chip_mode_in != ltmc_pkg::CHIP_NORMAL &&
			!to_failsafe) |=> mode[0] != `LTMC_MODE_NORMAL)
		else $error("Normal entered outside chip Normal.");
	// The block flag needs one cycle to set, so the driver is watched two cycles on.
	a_enable_block: assert property (@(posedge clock_in) disable iff (reset_in)
		!en_done[0] |-> ##2 !driver_dominant_out[0])
		else $error("Driver active before enable delay.");
	a_fault_sticky: assert property (@(posedge clock_in) disable iff (reset_in)
		xcvr_fault_flag_out[0] |=> xcvr_fault_flag_out[0])
		else $error("Fault flag cleared without reset.");
	a_failsafe_wake: assert property (@(posedge clock_in) disable iff (reset_in)
		to_failsafe |=> mode[0] == `LTMC_MODE_WAKE)
		else $error("Fail-Safe entry did not force wake mode.");
	a_slope_hold: assert property (@(posedge clock_in) disable iff (reset_in)
		!(!cs_prev && cs_sync) |=> $stable(slope_cfg_out))
		else $error("Slope settings changed without select rise.");
	a_rxonly_quiet: assert property (@(posedge clock_in) disable iff (reset_in)
		mode[1] == `LTMC_MODE_RXONLY |=> !driver_dominant_out[1])
		else $error("Driver active in receive-only mode.");
	a_wake_watchdog: assert property (@(posedge clock_in) disable iff (reset_in)
		(any_wake && chip_mode_in == ltmc_pkg::CHIP_STOP && watchdog_on_bus_wake_in &&
			!watchdog_enabled_in) |=> chip_req_out.watchdog_enable)
		else $error("Watchdog not enabled on Stop wake.");
endmodule : ltmc_top
`default_nettype wire

/* File: verif/ltmc_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Controller transmit pin and shared bus wire with pull-ups on both.
module ltmc_bus_model #(
	parameter int ENABLE_DELAY_CYC = 10
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [3:0] enable_in,
	input wire logic [3:0] want_dom_in,
	input wire logic early_in,
	input wire logic [3:0] remote_dom_in,
	input wire logic [3:0] driver_dominant_in,
	output logic [3:0] tx_out,
	output logic [3:0] bus_out
);
	int wait_cnt [4];
	// Restarts the enable wait at each enable, with margin for pin sync.
	always_ff @(posedge clock_in) begin
		for (int i = 0; i < 4; i++) begin
			if (reset_in || enable_in[i]) begin
				wait_cnt[i] <= ENABLE_DELAY_CYC + 4;
			end else if (wait_cnt[i] > 0) begin
				wait_cnt[i] <= wait_cnt[i] - 1;
			end
		end
	end
	// Transmit stays recessive until the wait ends, unless told to break it.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			tx_out[i] = !(want_dom_in[i] && (wait_cnt[i] == 0 || early_in));
			bus_out[i] = !(driver_dominant_in[i] || remote_dom_in[i]);
		end
	end
endmodule : ltmc_bus_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ltmc_defs.svh"
module tb;
	localparam int WF = 20;
	localparam int DT = 50;
	localparam int ED = 10;
	typedef struct packed {
		ltmc_pkg::ltmc_chip_mode_t chip;
		logic [1:0] idx;
		logic [1:0] mode;
		logic [1:0] want;
	} ltmc_row_t;
	ltmc_row_t rows [9];
	ltmc_pkg::ltmc_chip_mode_t chip;
	ltmc_pkg::ltmc_chip_req_t req;
	ltmc_pkg::ltmc_slope_cfg_t slope;
	logic clock_in, reset_in, early, txto, lsm, fls, cs_n, wdw, wde, uv;
	logic [3:0] wr, en, want, remote, tx, bus, rx, drv, flag, wstat;
	logic [1:0] wdata [4];
	logic [1:0] field [4];
	logic [1:0] exp_f [4];
	int fails, cmp_count, n_int, n_rst, n_wd, b, r;
	ltmc_top #(.WAKE_FILTER_CYC(WF), .DOM_TIMEOUT_CYC(DT), .ENABLE_DELAY_CYC(ED)) ltmc_top_i (
		.clock_in(clock_in), .reset_in(reset_in), .chip_mode_in(chip),
		.mode_wdata_in(wdata), .mode_write_in(wr), .tx_timeout_control_in(txto),
		.low_slope_select_in(lsm), .flash_speed_select_in(fls), .spi_chip_select_n_in(cs_n),
		.watchdog_on_bus_wake_in(wdw), .watchdog_enabled_in(wde),
		.bus_supply_undervoltage_in(uv), .bus_transmit_input_in(tx), .bus_level_in(bus),
		.bus_receive_output_out(rx), .driver_dominant_out(drv), .xcvr_mode_field_out(field),
		.xcvr_fault_flag_out(flag), .wake_status_reg_b_out(wstat), .chip_req_out(req),
		.slope_cfg_out(slope));
	ltmc_bus_model #(.ENABLE_DELAY_CYC(ED)) ltmc_bus_model_i (
		.clock_in(clock_in), .reset_in(reset_in), .enable_in(en), .want_dom_in(want),
		.early_in(early), .remote_dom_in(remote), .driver_dominant_in(drv), .tx_out(tx),
		.bus_out(bus));
	// Clock at 200 MHz.
	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	// Counts the one-cycle chip request pulses.
	always @(posedge clock_in) begin
		if (req.interrupt_n === 1'b0) n_int <= n_int + 1;
		if (req.go_restart === 1'b1) n_rst <= n_rst + 1;
		if (req.watchdog_enable === 1'b1) n_wd <= n_wd + 1;
	end
	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			fails++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
	endtask : cyc
	task automatic wr_mode(input int i, input logic [1:0] m);
		@(posedge clock_in);
		wdata[i] <= m;
		wr[i] <= 1'b1;
		en[i] <= (m == `LTMC_MODE_NORMAL);
		@(posedge clock_in);
		wr <= 4'h0;
		en <= 4'h0;
		cyc(3);
	endtask : wr_mode
	task automatic pulse(input int i, input int n);
		remote[i] <= 1'b1;
		cyc(n);
		remote[i] <= 1'b0;
		cyc(6);
	endtask : pulse
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	// Cuts a hang short.
	initial begin
		#50000;
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_sim();
	end
	// Main sequence.
	initial begin
		{fails, cmp_count, n_int, n_rst, n_wd} = '0;
		{early, txto, lsm, fls, wdw, wde, uv, wr, en, want, remote} = '0;
		wdata = '{default: 2'h0};
		exp_f = '{default: `LTMC_MODE_OFF};
		cs_n = 1'b1;
		chip = ltmc_pkg::CHIP_NORMAL;
		reset_in = 1'b1;
		rows = '{'{ltmc_pkg::CHIP_NORMAL, 2'h0, 2'h3, 2'h3}, '{ltmc_pkg::CHIP_NORMAL, 2'h0, 2'h0, 2'h0},
			'{ltmc_pkg::CHIP_STOP, 2'h1, 2'h3, 2'h0}, '{ltmc_pkg::CHIP_STOP, 2'h1, 2'h2, 2'h2},
			'{ltmc_pkg::CHIP_STOP, 2'h1, 2'h1, 2'h1}, '{ltmc_pkg::CHIP_SLEEP, 2'h2, 2'h2, 2'h0},
			'{ltmc_pkg::CHIP_SLEEP, 2'h2, 2'h1, 2'h1}, '{ltmc_pkg::CHIP_RESTART, 2'h3, 2'h1, 2'h1},
			'{ltmc_pkg::CHIP_FAILSAFE, 2'h1, 2'h0, 2'h0}};
		cyc(5);
		reset_in <= 1'b0;
		cyc(4);
		check(rx === 4'hf && drv === 4'h0 && flag === 4'h0 && wstat === 4'h0, "reset");
		check(field[0] === 2'h0 && field[3] === 2'h0 && req.interrupt_n === 1'b1, "off");
		check(slope === 2'h0, "slope default");
		$display("reset test done");
		foreach (rows[k]) begin
			chip <= rows[k].chip;
			cyc(3);
			if (rows[k].chip == ltmc_pkg::CHIP_FAILSAFE) exp_f = '{default: `LTMC_MODE_WAKE};
			wr_mode(rows[k].idx, rows[k].mode);
			exp_f[rows[k].idx] = rows[k].want;
			for (int j = 0; j < 4; j++) check(field[j] === exp_f[j], "mode field");
		end
		$display("mode table done");
		chip <= ltmc_pkg::CHIP_NORMAL;
		wr_mode(0, `LTMC_MODE_NORMAL);
		early <= 1'b1;
		want[0] <= 1'b1;
		cyc(ED + 10);
		check(drv[0] === 1'b0, "early dominant passed");
		early <= 1'b0;
		want[0] <= 1'b0;
		cyc(4);
		want[0] <= 1'b1;
		cyc(8);
		check(drv[0] === 1'b1 && rx[0] === 1'b0, "next dominant");
		cyc(DT + 10);
		check(drv[0] === 1'b0 && flag[0] === 1'b1, "tx timeout");
		want[0] <= 1'b0;
		cyc(6);
		want[0] <= 1'b1;
		cyc(6);
		check(drv[0] === 1'b1, "driver back");
		want[0] <= 1'b0;
		txto <= 1'b1;
		wr_mode(2, `LTMC_MODE_NORMAL);
		cyc(ED + 6);
		want[2] <= 1'b1;
		cyc(DT + 10);
		check(drv[2] === 1'b1, "timeout disabled");
		uv <= 1'b1;
		cyc(8);
		check(drv[2] === 1'b0 && rx[2] === 1'b1, "undervoltage");
		uv <= 1'b0;
		cyc(6);
		check(drv[2] === 1'b1, "supply back");
		want[2] <= 1'b0;
		txto <= 1'b0;
		wr_mode(1, `LTMC_MODE_RXONLY);
		remote[1] <= 1'b1;
		cyc(8);
		check(rx[1] === 1'b0 && drv[1] === 1'b0, "receive only");
		cyc(DT + 10);
		check(flag[1] === 1'b1 && field[1] === `LTMC_MODE_RXONLY, "bus clamp");
		remote[1] <= 1'b0;
		$display("transmit tests done");
		chip <= ltmc_pkg::CHIP_STOP;
		wdw <= 1'b1;
		cyc(4);
		b = n_int;
		pulse(3, 8);
		check(rx[3] === 1'b1 && wstat[3] === 1'b0, "short pulse");
		pulse(3, WF + 20);
		check(rx[3] === 1'b0 && field[3] === `LTMC_MODE_WAKE, "wake");
		check(wstat[3] === 1'b1 && n_int == b + 1 && n_wd > 0, "wake stop");
		chip <= ltmc_pkg::CHIP_SLEEP;
		cyc(6);
		check(rx[3] === 1'b1, "rearm");
		b = n_int;
		r = n_rst;
		pulse(3, WF + 20);
		check(n_rst > r && n_int == b && rx[3] === 1'b0, "wake sleep");
		wr_mode(3, `LTMC_MODE_OFF);
		r = n_rst;
		pulse(3, WF + 20);
		check(n_rst == r && n_int == b, "off wake");
		$display("wake tests done");
		chip <= ltmc_pkg::CHIP_NORMAL;
		lsm <= 1'b1;
		fls <= 1'b1;
		cs_n <= 1'b0;
		cyc(6);
		check(slope === 2'h0, "before select rise");
		cs_n <= 1'b1;
		cyc(6);
		check(slope === 2'h3, "slope latched");
		chip <= ltmc_pkg::CHIP_STOP;
		lsm <= 1'b0;
		cs_n <= 1'b0;
		cyc(6);
		cs_n <= 1'b1;
		cyc(6);
		check(slope.low_slope === 1'b1, "write outside normal");
		$display("slope tests done");
		reset_in <= 1'b1;
		cyc(5);
		reset_in <= 1'b0;
		cyc(4);
		check(rx === 4'hf && drv === 4'h0 && flag === 4'h0 && wstat === 4'h0, "reset again");
		check(field[0] === 2'h0 && field[2] === 2'h0 && slope === 2'h0, "reset modes");
		$display("mid-run reset test done");
		end_sim();
	end
endmodule : tb
`default_nettype wire
